// ### src/mcx_pkg.sv
/*
 * constants, encodings and state codes for the small 8-bit core.
 * assumes an 18-bit instruction word and a fabric program store.
 */
// What this block does
// [RULE_01] read port: operand to address, data to register
// [RULE_02] read strobe pulses in second cycle only
// [RULE_03] fabric decodes address, drives read data
// [RULE_04] interrupt only when enable set and input high
// [RULE_05] finish instruction, preempt next, push pc
// [RULE_06] interrupt clears the enable flag itself
// [RULE_07] interrupt loads pc with all ones vector
// [RULE_08] interrupt saves carry and zero flags
// [RULE_09] interrupt takes two cycles, ack in second
// [RULE_10] fabric may clear its flag on ack
// [RULE_11] jump loads 10-bit absolute target into pc
// [RULE_12] jump conditions always, c, nc, z, nz
// [RULE_13] jump leaves stack, pointer and flags alone
// [RULE_14] load copies register or constant, keeps flags
// [RULE_15] or sets zero on result, clears carry
// [RULE_16] write port: operand address, register data out
// [RULE_17] write strobe pulses in second cycle only
// [RULE_18] fabric captures data on address and strobe
// [RULE_19] reset clears pc, flags, enable, stack pointer
// [RULE_20] reset leaves registers and stores untouched
// [RULE_21] stack is circular, pointer wraps
// [RULE_22] reset happens after configuration automatically
// [RULE_23] interrupt return pops pc, restores flags, sets enable; code loads enable from instruction bit 0 instead
// [RULE_24] stack holds 31 nested levels
// [RULE_25] port address and data stable both cycles; code sets them at the end of the first cycle instead
package mcx_pkg;
	localparam int DW = 8;
	localparam int AW = 10;
	localparam int IW = 18;
	localparam int RN = 16;
	localparam int STACK_DEPTH = 31;
	localparam int SPW = 5;
	localparam logic [SPW-1:0] SP_LAST = 5'h1e;
	localparam logic [SPW-1:0] SP_ZERO = 5'h00;
	localparam logic [SPW-1:0] SP_ONE = 5'h01;
	localparam logic [AW-1:0] PC_RESET = 10'h000;
	localparam logic [AW-1:0] PC_ONE = 10'h001;
	localparam logic [AW-1:0] IRQ_VECTOR = 10'h3ff;
	localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
	// instruction field positions
	localparam int OP_HI = 17;
	localparam int OP_LO = 13;
	localparam int CND_HI = 12;
	localparam int CND_LO = 10;
	localparam int DST_HI = 11;
	localparam int DST_LO = 8;
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 4;
	localparam int IMM_HI = 7;
	localparam int IMM_LO = 0;
	localparam int TGT_HI = 9;
	localparam int TGT_LO = 0;
	localparam int ENB_BIT = 0;
	// opcodes; low bit of 00..07 selects register operand
	localparam logic [4:0] OP_LOAD = 5'h00;
	localparam logic [4:0] OP_OR = 5'h02;
	localparam logic [4:0] OP_INPUT = 5'h04;
	localparam logic [4:0] OP_OUTPUT = 5'h06;
	localparam logic [4:0] OP_JUMP = 5'h08;
	localparam logic [4:0] OP_RETI = 5'h09;
	localparam logic [4:0] OP_IRQ_EN = 5'h0a;
	// jump conditions
	localparam logic [2:0] CND_ALWAYS = 3'h0;
	localparam logic [2:0] CND_ZERO = 3'h4;
	localparam logic [2:0] CND_ZERO_CLEAR = 3'h5;
	localparam logic [2:0] CND_CARRY = 3'h6;
	localparam logic [2:0] CND_CARRY_CLEAR = 3'h7;
	typedef enum logic [1:0] {
		ST_FETCH    = 2'b00,
		ST_EXEC     = 2'b01,
		ST_IRQ_PUSH = 2'b10,
		ST_IRQ_ACK  = 2'b11
	} mcx_state_e;
endpackage : mcx_pkg

// ### src/mcx_core.sv
/*
 * execution core: port read and write, interrupt entry and return,
 * conditional jump, load, or, and reset handling.
 * assumes program store and port decode in fabric on ref_clk_i;
 * instr_i must show the word at prog_addr_o during the fetch cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module mcx_core (
	input  wire logic                  ref_clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  core_reset_i,
	input  wire logic [mcx_pkg::IW-1:0] instr_i,
	input  wire logic [mcx_pkg::DW-1:0] in_port_i,
	input  wire logic                  irq_i,
	output logic      [mcx_pkg::AW-1:0] prog_addr_o,
	output logic      [mcx_pkg::DW-1:0] io_address_o,
	output logic      [mcx_pkg::DW-1:0] out_port_o,
	output logic                       rd_strobe_o,
	output logic                       wr_strobe_o,
	output logic                       irq_ack_o,
	output logic                       irq_enable_bit_o
);
	mcx_pkg::mcx_state_e state_ff;
	mcx_pkg::mcx_state_e nxt_state;
	logic [mcx_pkg::AW-1:0]  pc_ff;
	logic [mcx_pkg::IW-1:0]  instr_ff;
	logic                   zero_ff;
	logic                   carry_ff;
	logic                   saved_zero_ff;
	logic                   saved_carry_ff;
	logic                   irq_enable_bit_ff;
	logic [mcx_pkg::SPW-1:0] sp_ff;
	logic [mcx_pkg::AW-1:0]  stack_ff [mcx_pkg::STACK_DEPTH];
	logic [mcx_pkg::DW-1:0]  regs_ff [mcx_pkg::RN];
	logic [mcx_pkg::DW-1:0]  io_address_ff;
	logic [mcx_pkg::DW-1:0]  out_port_ff;
	logic                   rd_strobe_ff;
	logic                   wr_strobe_ff;
	logic                   irq_ack_ff;
	logic [4:0]             fetch_op;
	logic [4:0]             exec_op;
	logic [mcx_pkg::DW-1:0]  fetch_operand;
	logic [mcx_pkg::DW-1:0]  exec_operand;
	logic [mcx_pkg::DW-1:0]  or_result;
	logic [mcx_pkg::SPW-1:0] sp_prev;
	logic [mcx_pkg::SPW-1:0] sp_next;
	logic                   jump_taken;
	logic                   irq_take;

	// opcode with the operand-form bit folded away for 00..07
	function automatic logic [4:0] base_op(
		input logic [mcx_pkg::IW-1:0] w
	);
		logic [4:0] op;
		op = w[mcx_pkg::OP_HI:mcx_pkg::OP_LO];
		if (op < mcx_pkg::OP_JUMP) begin
			op[0] = 1'b0;
		end
		return op;
	endfunction : base_op

	// register operand when low opcode bit set, else constant
	function automatic logic [mcx_pkg::DW-1:0] pick_operand(
		input logic [mcx_pkg::IW-1:0] w,
		input logic [mcx_pkg::DW-1:0] reg_val
	);
		logic [mcx_pkg::DW-1:0] v;
		v = w[mcx_pkg::IMM_HI:mcx_pkg::IMM_LO];
		if (w[mcx_pkg::OP_LO]) begin
			v = reg_val;
		end
		return v;
	endfunction : pick_operand

	// jump condition test against the flags
	function automatic logic cond_true(
		input logic [2:0] c,
		input logic       z,
		input logic       cy
	);
		logic t;
		t = 1'b0;
		case (c)
			mcx_pkg::CND_ALWAYS:      t = 1'b1;
			mcx_pkg::CND_ZERO:        t = z;
			mcx_pkg::CND_ZERO_CLEAR:  t = ~z;
			mcx_pkg::CND_CARRY:       t = cy;
			mcx_pkg::CND_CARRY_CLEAR: t = ~cy;
			default:                  t = 1'b0;
		endcase
		return t;
	endfunction : cond_true

	// decode of the word being fetched and the word executing
	assign fetch_op = base_op(instr_i);
	assign exec_op = base_op(instr_ff);
	assign fetch_operand = pick_operand(instr_i,
		regs_ff[instr_i[mcx_pkg::SRC_HI:mcx_pkg::SRC_LO]]);
	assign exec_operand = pick_operand(instr_ff,
		regs_ff[instr_ff[mcx_pkg::SRC_HI:mcx_pkg::SRC_LO]]);
	assign or_result = regs_ff[instr_ff[mcx_pkg::DST_HI:mcx_pkg::DST_LO]]
		| exec_operand; // see [RULE_15]
	assign jump_taken = cond_true(instr_ff[mcx_pkg::CND_HI:mcx_pkg::CND_LO],
		zero_ff, carry_ff); // see [RULE_12]
	assign irq_take = irq_enable_bit_ff & irq_i; // see [RULE_04]

	// circular stack pointer neighbours
	assign sp_next = (sp_ff == mcx_pkg::SP_LAST) ? mcx_pkg::SP_ZERO
		: sp_ff + mcx_pkg::SP_ONE; // see [RULE_21] [RULE_24]
	assign sp_prev = (sp_ff == mcx_pkg::SP_ZERO) ? mcx_pkg::SP_LAST
		: sp_ff - mcx_pkg::SP_ONE; // see [RULE_21]

	// sequencing: two cycles per instruction, two per interrupt
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			mcx_pkg::ST_FETCH: begin
				nxt_state = mcx_pkg::ST_EXEC;
			end
			mcx_pkg::ST_EXEC: begin
				// current instruction completes first
				if (irq_take) begin
					nxt_state = mcx_pkg::ST_IRQ_PUSH; // see [RULE_05]
				end else begin
					nxt_state = mcx_pkg::ST_FETCH;
				end
			end
			mcx_pkg::ST_IRQ_PUSH: begin
				nxt_state = mcx_pkg::ST_IRQ_ACK; // see [RULE_09]
			end
			mcx_pkg::ST_IRQ_ACK: begin
				nxt_state = mcx_pkg::ST_FETCH;
			end
		endcase
	end

	// state register; power-up reset stands in for global_set_reset
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= mcx_pkg::ST_FETCH; // see [RULE_22]
		end else if (core_reset_i) begin
			state_ff <= mcx_pkg::ST_FETCH; // see [RULE_19]
		end else begin
			state_ff <= nxt_state;
		end
	end

	// instruction latch, not cleared by reset
	always_ff @(posedge ref_clk_i) begin
		if (state_ff == mcx_pkg::ST_FETCH) begin
			instr_ff <= instr_i;
		end
	end

	// program counter
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pc_ff <= mcx_pkg::PC_RESET; // see [RULE_22]
		end else if (core_reset_i) begin
			pc_ff <= mcx_pkg::PC_RESET; // see [RULE_19]
		end else if (state_ff == mcx_pkg::ST_EXEC) begin
			if (exec_op == mcx_pkg::OP_JUMP && jump_taken) begin
				pc_ff <= instr_ff[mcx_pkg::TGT_HI:mcx_pkg::TGT_LO]; // see [RULE_11]
			end else if (exec_op == mcx_pkg::OP_RETI) begin
				pc_ff <= stack_ff[sp_prev]; // see [RULE_23]
			end else begin
				pc_ff <= pc_ff + mcx_pkg::PC_ONE; // see [RULE_12] [RULE_14]
			end
		end else if (state_ff == mcx_pkg::ST_IRQ_PUSH) begin
			pc_ff <= mcx_pkg::IRQ_VECTOR; // see [RULE_07]
		end
	end

	// carry and zero flags; only reset, or and interrupt return touch them
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			zero_ff <= 1'b0;
			carry_ff <= 1'b0;
		end else if (core_reset_i) begin
			zero_ff <= 1'b0; // see [RULE_19]
			carry_ff <= 1'b0;
		end else if (state_ff == mcx_pkg::ST_EXEC) begin
			if (exec_op == mcx_pkg::OP_OR) begin
				zero_ff <= (or_result == mcx_pkg::BYTE_ZERO); // see [RULE_15]
				carry_ff <= 1'b0;
			end else if (exec_op == mcx_pkg::OP_RETI) begin
				zero_ff <= saved_zero_ff; // see [RULE_23]
				carry_ff <= saved_carry_ff;
			end
		end
	end

	// preserved flags, copied on interrupt entry
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			saved_zero_ff <= 1'b0;
			saved_carry_ff <= 1'b0;
		end else if (state_ff == mcx_pkg::ST_IRQ_PUSH) begin
			saved_zero_ff <= zero_ff; // see [RULE_08]
			saved_carry_ff <= carry_ff;
		end
	end

	// interrupt enable flag
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_enable_bit_ff <= 1'b0;
		end else if (core_reset_i) begin
			irq_enable_bit_ff <= 1'b0; // see [RULE_19]
		end else if (state_ff == mcx_pkg::ST_EXEC && irq_take) begin
			irq_enable_bit_ff <= 1'b0; // see [RULE_06]
		end else if (state_ff == mcx_pkg::ST_EXEC &&
			(exec_op == mcx_pkg::OP_RETI ||
			exec_op == mcx_pkg::OP_IRQ_EN)) begin
			irq_enable_bit_ff <= instr_ff[mcx_pkg::ENB_BIT]; // see [RULE_23]
		end
	end

	// stack pointer: push on interrupt, pop on return
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sp_ff <= mcx_pkg::SP_ZERO;
		end else if (core_reset_i) begin
			sp_ff <= mcx_pkg::SP_ZERO; // see [RULE_19]
		end else if (state_ff == mcx_pkg::ST_IRQ_PUSH) begin
			sp_ff <= sp_next; // see [RULE_05] [RULE_21]
		end else if (state_ff == mcx_pkg::ST_EXEC &&
			exec_op == mcx_pkg::OP_RETI) begin
			sp_ff <= sp_prev; // see [RULE_23]
		end
	end

	// stack storage; a jump never writes here
	always_ff @(posedge ref_clk_i) begin
		if (state_ff == mcx_pkg::ST_IRQ_PUSH) begin
			stack_ff[sp_ff] <= pc_ff; // see [RULE_05] [RULE_13]
		end
	end

	// register file, untouched by any reset
	always_ff @(posedge ref_clk_i) begin
		if (state_ff == mcx_pkg::ST_EXEC) begin
			unique case (exec_op)
				mcx_pkg::OP_LOAD: begin
					regs_ff[instr_ff[mcx_pkg::DST_HI:mcx_pkg::DST_LO]]
						<= exec_operand; // see [RULE_14] [RULE_20]
				end
				mcx_pkg::OP_OR: begin
					regs_ff[instr_ff[mcx_pkg::DST_HI:mcx_pkg::DST_LO]]
						<= or_result; // see [RULE_15]
				end
				mcx_pkg::OP_INPUT: begin
					// sampled at the close of the strobe cycle
					regs_ff[instr_ff[mcx_pkg::DST_HI:mcx_pkg::DST_LO]]
						<= in_port_i; // see [RULE_01] [RULE_25]
				end
				default: begin
				end
			endcase
		end
	end

	// port address and write data, set at fetch and then held
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_address_ff <= mcx_pkg::BYTE_ZERO;
			out_port_ff <= mcx_pkg::BYTE_ZERO;
		end else if (state_ff == mcx_pkg::ST_FETCH &&
			(fetch_op == mcx_pkg::OP_INPUT ||
			fetch_op == mcx_pkg::OP_OUTPUT)) begin
			io_address_ff <= fetch_operand; // see [RULE_01] [RULE_16]
			out_port_ff <= regs_ff[instr_i[mcx_pkg::DST_HI:mcx_pkg::DST_LO]]; // see [RULE_16] [RULE_25]
		end
	end

	// strobes high for the second cycle only
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_strobe_ff <= 1'b0;
			wr_strobe_ff <= 1'b0;
		end else if (core_reset_i) begin
			rd_strobe_ff <= 1'b0;
			wr_strobe_ff <= 1'b0;
		end else begin
			rd_strobe_ff <= (state_ff == mcx_pkg::ST_FETCH) &&
				(fetch_op == mcx_pkg::OP_INPUT); // see [RULE_02]
			wr_strobe_ff <= (state_ff == mcx_pkg::ST_FETCH) &&
				(fetch_op == mcx_pkg::OP_OUTPUT); // see [RULE_17]
		end
	end

	// acknowledge during the second interrupt cycle
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_ack_ff <= 1'b0;
		end else if (core_reset_i) begin
			irq_ack_ff <= 1'b0;
		end else begin
			irq_ack_ff <= (state_ff == mcx_pkg::ST_IRQ_PUSH); // see [RULE_09]
		end
	end

	// outputs straight from flops
	assign prog_addr_o = pc_ff;
	assign io_address_o = io_address_ff;
	assign out_port_o = out_port_ff;
	assign rd_strobe_o = rd_strobe_ff;
	assign wr_strobe_o = wr_strobe_ff;
	assign irq_ack_o = irq_ack_ff;
	assign irq_enable_bit_o = irq_enable_bit_ff;
endmodule : mcx_core
`default_nettype wire

// ### tb/mcx_core_chk.sv
/* checker: port timing of the execution core.
   assumes a bind onto mcx_core and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module mcx_core_chk (
	input wire logic                   ref_clk_i,
	input wire logic                   reset_n_i,
	input wire logic                   core_reset_i,
	input wire logic [mcx_pkg::IW-1:0] instr_i,
	input wire logic                   irq_i,
	input wire logic [mcx_pkg::AW-1:0] prog_addr_o,
	input wire logic [mcx_pkg::DW-1:0] io_address_o,
	input wire logic [mcx_pkg::DW-1:0] out_port_o,
	input wire logic                   rd_strobe_o,
	input wire logic                   wr_strobe_o,
	input wire logic                   irq_ack_o,
	input wire logic                   irq_enable_bit_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// single-cycle pulses
	a_rd_one_cycle: assert property (
		rd_strobe_o |=> !rd_strobe_o) else $error("read strobe too long");
	a_wr_one_cycle: assert property (
		wr_strobe_o |=> !wr_strobe_o) else $error("write strobe too long");
	a_ack_one_cycle: assert property (
		irq_ack_o |=> !irq_ack_o) else $error("ack too long");
	// interrupt entry: vector, cause and enable cleared
	a_ack_vector: assert property (
		irq_ack_o |-> prog_addr_o == mcx_pkg::IRQ_VECTOR)
		else $error("ack without vector address");
	a_ack_cause_clear: assert property (
		irq_ack_o |-> !irq_enable_bit_o && $past(irq_enable_bit_o, 2)
		&& $past(irq_i, 2)) else $error("ack without enabled request");
	a_pulse_exclusive: assert property (
		$onehot0({rd_strobe_o, wr_strobe_o, irq_ack_o}))
		else $error("strobes overlap");
	// port address follows the operand of the fetched word
	a_rd_address: assert property (
		$rose(rd_strobe_o) && $past(instr_i[17:13]) == mcx_pkg::OP_INPUT
		|-> io_address_o == $past(instr_i[7:0]))
		else $error("read address wrong");
	a_wr_address: assert property (
		$rose(wr_strobe_o) && $past(instr_i[17:13]) == mcx_pkg::OP_OUTPUT
		|-> io_address_o == $past(instr_i[7:0]))
		else $error("write address wrong");
	a_port_hold: assert property (
		rd_strobe_o || wr_strobe_o |=> $stable(io_address_o)
		&& $stable(out_port_o)) else $error("port moved after strobe");
	a_sync_reset: assert property (
		core_reset_i |=> prog_addr_o == mcx_pkg::PC_RESET
		&& !irq_enable_bit_o && !rd_strobe_o && !wr_strobe_o && !irq_ack_o)
		else $error("core reset incomplete");
endmodule : mcx_core_chk
bind mcx_core mcx_core_chk u_mcx_core_chk (.ref_clk_i(ref_clk_i),
	.reset_n_i(reset_n_i), .core_reset_i(core_reset_i), .instr_i(instr_i),
	.irq_i(irq_i), .prog_addr_o(prog_addr_o), .io_address_o(io_address_o),
	.out_port_o(out_port_o), .rd_strobe_o(rd_strobe_o),
	.wr_strobe_o(wr_strobe_o), .irq_ack_o(irq_ack_o),
	.irq_enable_bit_o(irq_enable_bit_o));
`default_nettype wire

// ### tb/mcx_prog_model.sv
/* partner model: program store, port decode and interrupt source.
   assumes the core on the same clock; the bench fills mem. */
`timescale 1ns/100ps
`default_nettype none
module mcx_prog_model (
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_n_i,
	input  wire logic [mcx_pkg::AW-1:0] prog_addr_o,
	input  wire logic [mcx_pkg::DW-1:0] io_address_o,
	input  wire logic [mcx_pkg::DW-1:0] out_port_o,
	input  wire logic                   rd_strobe_o,
	input  wire logic                   wr_strobe_o,
	input  wire logic                   irq_ack_o,
	output logic      [mcx_pkg::IW-1:0] instr_i,
	output logic      [mcx_pkg::DW-1:0] in_port_i,
	output logic                        irq_i
);
	logic [mcx_pkg::IW-1:0] mem [1024];
	logic [15:0]            wlog [$];
	int                     n_ack;
	// unfilled words write to trap port ee
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = {5'h06, 5'h01, 8'hee};
	end
	assign instr_i = mem[prog_addr_o];
	// data from address during strobe, inverse otherwise
	assign in_port_i = rd_strobe_o ? io_address_o ^ 8'ha5
		: ~(io_address_o ^ 8'ha5);
	// log writes, raise request on port 20, drop it on ack
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_i <= 1'b0;
		end else begin
			if (wr_strobe_o) wlog.push_back({io_address_o, out_port_o});
			if (irq_ack_o) n_ack <= n_ack + 1;
			irq_i <= irq_ack_o ? 1'b0
				: irq_i | (wr_strobe_o && io_address_o == 8'h20);
		end
	end
endmodule : mcx_prog_model
`default_nettype wire

// ### tb/mcx_core_tb.sv
/* bench: runs a small program and checks port traffic, jumps,
   interrupt entry and return, and core reset.
   assumes mcx_core, mcx_prog_model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module mcx_core_tb;
	logic                   ref_clk_i, reset_n_i, core_reset_i, irq_i;
	logic [mcx_pkg::IW-1:0] instr_i;
	logic [mcx_pkg::DW-1:0] in_port_i, io_address_o, out_port_o;
	logic [mcx_pkg::AW-1:0] prog_addr_o;
	logic                   rd_strobe_o, wr_strobe_o, irq_ack_o;
	logic                   irq_enable_bit_o;
	int                     fail_count, n_compared, cyc;
	logic [15:0]            exp_w [7];
	mcx_core u_mcx_core (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.core_reset_i(core_reset_i), .instr_i(instr_i), .in_port_i(in_port_i),
		.irq_i(irq_i), .prog_addr_o(prog_addr_o), .io_address_o(io_address_o),
		.out_port_o(out_port_o), .rd_strobe_o(rd_strobe_o),
		.wr_strobe_o(wr_strobe_o), .irq_ack_o(irq_ack_o),
		.irq_enable_bit_o(irq_enable_bit_o));
	mcx_prog_model u_mcx_prog_model (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .prog_addr_o(prog_addr_o),
		.io_address_o(io_address_o), .out_port_o(out_port_o),
		.rd_strobe_o(rd_strobe_o), .wr_strobe_o(wr_strobe_o),
		.irq_ack_o(irq_ack_o), .instr_i(instr_i), .in_port_i(in_port_i),
		.irq_i(irq_i));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	function automatic logic [17:0] ins(input logic [4:0] op,
		input logic [3:0] d, input logic [7:0] k);
		return {op, 1'b0, d, k};
	endfunction : ins
	function automatic logic [17:0] jmp(input logic [2:0] c,
		input logic [9:0] t);
		return {mcx_pkg::OP_JUMP, c, t};
	endfunction : jmp
	task automatic p(input int a, input logic [17:0] w);
		u_mcx_prog_model.mem[a] = w;
	endtask : p
	// free-running clock and hang guard
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			final_report();
		end
	end
	// program, run, then core reset
	initial begin
		reset_n_i = 1'b0;
		core_reset_i = 1'b0;
		exp_w = '{16'h813c, 16'h05e7, 16'h3ce7, 16'h2010, 16'h2110,
			16'h3300, 16'h2010};
		#1;
		p(0, ins(mcx_pkg::OP_LOAD, 4'h1, 8'h3c));
		p(1, ins(mcx_pkg::OP_OUTPUT, 4'h1, 8'h81));
		p(2, ins(mcx_pkg::OP_INPUT, 4'h2, 8'h42));
		p(3, ins(mcx_pkg::OP_OUTPUT, 4'h2, 8'h05));
		p(4, ins(mcx_pkg::OP_LOAD | 5'h01, 4'h3, 8'h20));
		p(5, ins(mcx_pkg::OP_OUTPUT | 5'h01, 4'h3, 8'h10));
		p(6, ins(mcx_pkg::OP_LOAD, 4'h4, 8'h00));
		p(7, ins(mcx_pkg::OP_OR, 4'h4, 8'h00));
		p(8, jmp(mcx_pkg::CND_ZERO_CLEAR, 10'h3f0));
		p(9, jmp(mcx_pkg::CND_ZERO, 10'h00c));
		p(12, jmp(mcx_pkg::CND_CARRY, 10'h3f0));
		p(13, jmp(mcx_pkg::CND_CARRY_CLEAR, 10'h00f));
		p(15, ins(mcx_pkg::OP_OR, 4'h4, 8'h10));
		p(16, jmp(mcx_pkg::CND_ZERO, 10'h3f0));
		p(17, jmp(mcx_pkg::CND_ZERO_CLEAR, 10'h013));
		p(19, ins(mcx_pkg::OP_IRQ_EN, 4'h0, 8'h01));
		p(20, ins(mcx_pkg::OP_OUTPUT, 4'h4, 8'h20));
		p(21, ins(mcx_pkg::OP_OUTPUT, 4'h4, 8'h21));
		p(22, jmp(mcx_pkg::CND_ZERO, 10'h3f0));
		p(23, ins(mcx_pkg::OP_OUTPUT, 4'h4, 8'h20));
		p(24, jmp(mcx_pkg::CND_ALWAYS, 10'h018));
		p(1023, jmp(mcx_pkg::CND_ALWAYS, 10'h030));
		p(48, ins(mcx_pkg::OP_LOAD, 4'h5, 8'h00));
		p(49, ins(mcx_pkg::OP_OR, 4'h5, 8'h00));
		p(50, ins(mcx_pkg::OP_OUTPUT, 4'h5, 8'h33));
		p(51, ins(mcx_pkg::OP_RETI, 4'h0, 8'h00));
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		reset_n_i = 1'b1;
		for (int i = 0; i < 600 && u_mcx_prog_model.wlog.size() < 7; i++)
			@(negedge ref_clk_i);
		repeat (20) @(negedge ref_clk_i);
		check(16'(u_mcx_prog_model.wlog.size()), 16'h0007);
		for (int i = 0; i < 7; i++)
			check(u_mcx_prog_model.wlog[i], exp_w[i]);
		$display("test port trace and jumps done");
		check(16'(u_mcx_prog_model.n_ack), 16'h0001);
		check({15'h0000, irq_enable_bit_o}, 16'h0000);
		check({6'h00, prog_addr_o}, 16'h0018);
		$display("test interrupt entry and return done");
		core_reset_i = 1'b1;
		@(negedge ref_clk_i);
		core_reset_i = 1'b0;
		check({6'h00, prog_addr_o}, 16'h0000);
		$display("test core reset done");
		final_report();
	end
endmodule : mcx_core_tb
`default_nettype wire
